// >>> test/asp_host_model.sv
// Host model: serial master that drives frames into the command port.
// Assumes 1 ns units; its link clock runs from delays, unrelated to clk_i.
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
    // Serial pins
    output logic      frame_sel_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_n_i
);
    localparam int HALF_NS = 24;

    // Released line floats to its pull-up
    logic sdo_line;
    assign sdo_line = sdo_oe_n_i ? 1'b1 : sdo_i;

    initial begin
        frame_sel_o = 1'b0;
        sclk_o      = 1'b0;
        sdi_o       = 1'b0;
    end

    // One frame of n clocks, command bits repeat past eight
    task automatic xfer(input logic [7:0] cmd, input int n,
                        output logic [7:0] resp, output logic drove);
        resp        = 8'h00;
        drove       = 1'b1;
        frame_sel_o = 1'b1;
        for (int i = 0; i < n; i++) begin
            sdi_o = cmd[7 - (i % 8)];
            #HALF_NS;
            resp   = {resp[6:0], sdo_line};
            drove  = drove & (sdo_oe_n_i === 1'b0);
            sclk_o = 1'b1;
            #HALF_NS;
            sclk_o = 1'b0;
        end
        #HALF_NS;
        frame_sel_o = 1'b0;
        sdi_o       = ~sdi_o;
        #(2 * HALF_NS);
    endtask : xfer
endmodule : asp_host_model
`default_nettype wire

// >>> test/tb_asp_port.sv
// Self-checking bench for the serial command port.
// Assumes the host model in asp_host_model.sv and a 200 MHz clk_i.
`timescale 1ns/1ps
`default_nettype none
module tb_asp_port;
    import asp_pkg::*;

    logic        clk_i       = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic        en_i        = 1'b1;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        irq_o;
    logic        frame_sel;
    logic        sclk;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe_n_o;
    logic [5:0]  stat_f      = 6'h0;
    logic [3:0]  flt_f       = 4'h0;
    logic [3:0]  squib;
    logic [3:0]  mux;
    logic [3:0]  low;
    logic [3:0]  aux;
    logic [3:0]  high;
    logic [19:0] exp_outs    = 20'h0;
    logic [7:0]  prev        = 8'h00;
    int          error_cnt   = 0;
    int          n_tests     = 0;

    always #2.5 clk_i = ~clk_i;

    asp_port dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
        .frame_sel_i(frame_sel), .sclk_i(sclk), .sdi_i(sdi),
        .sdo_o(sdo_o), .sdo_oe_n_o(sdo_oe_n_o),
        .loop1_drivers_active_i(stat_f[5]), .loop2_drivers_active_i(stat_f[4]),
        .safing_closed_flag_i(stat_f[3]), .reserve_low_flag_i(stat_f[2]),
        .battery_low_flag_i(stat_f[1]), .pump_low_flag_i(stat_f[0]),
        .loop2_high_over_flag_i(flt_f[3]), .loop1_high_over_flag_i(flt_f[2]),
        .loop2_low_under_flag_i(flt_f[1]), .loop1_low_under_flag_i(flt_f[0]),
        .squib_sel_o(squib), .mux_sel_o(mux), .low_side_o(low),
        .aux_ctrl_o(aux), .high_side_o(high)
    );

    asp_host_model host (
        .frame_sel_o(frame_sel), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo_o), .sdo_oe_n_i(sdo_oe_n_o)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask : rchk

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_i);
        #1 chk({31'h0, irq_o}, {31'h0, exp});
    endtask : irq_chk

    // Frame plus pin, response and output checks
    task automatic frame(input logic [7:0] cmd, input int n, input logic [7:0] exp_r);
        logic [7:0] r;
        logic       d;
        host.xfer(cmd, n, r, d);
        chk({31'h0, d & sdo_oe_n_o}, 32'h1);
        if (n == 8) chk({24'h0, r}, {24'h0, exp_r});
        chk({12'h0, squib, mux, low, aux, high}, {12'h0, exp_outs});
    endtask : frame

    task automatic t_reset;
        rchk(OFS_CTRL, 32'h1);
        rchk(OFS_IRQ_STAT, 32'h0);
        rchk(OFS_IRQ_MASK, 32'h0);
        rchk(OFS_LAST_CMD, 32'h0);
        wr(4'h2, 32'hffff_ffff);
        rchk(4'h2, 32'h0);
        chk({30'h0, irq_o, sdo_oe_n_o}, 32'h1);
    endtask : t_reset

    task automatic t_cmds;
        logic [3:0] code [5];
        logic [7:0] c;
        code = '{CMD_SQUIB, CMD_MUX, CMD_LOW, CMD_AUX, CMD_HIGH};
        for (int k = 0; k < 5; k++) begin
            c = {code[k], 4'h9 - 4'(k)};
            exp_outs[19 - 4 * k -: 4] = c[3:0];
            frame(c, 8, prev);
            prev = c;
        end
        rchk(OFS_LAST_CMD, {24'h0, prev});
    endtask : t_cmds

    task automatic t_reads;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_i);
            stat_f <= p ? 6'h2d : 6'h12;
            flt_f  <= p ? 4'h6 : 4'h9;
            frame(8'h1f, 8, prev);
            frame(8'h2a, 8, {2'h0, stat_f});
            frame(8'h10, 8, {4'h0, flt_f});
            exp_outs[11:8] = 4'hc;
            frame(8'h5c, 8, {2'h0, stat_f});
            prev = 8'h5c;
        end
    endtask : t_reads

    task automatic t_err;
        wr(OFS_IRQ_STAT, 32'h7);
        frame(8'h53, 7, 8'h00);
        rchk(OFS_LAST_CMD, {24'h0, prev});
        rchk(OFS_IRQ_STAT, 32'h1);
        frame(8'h53, 9, 8'h00);
        exp_outs[11:8] = 4'h3;
        frame(8'h53, 8, ERR_CODE);
        exp_outs[7:4] = 4'he;
        frame(8'h6e, 8, 8'h53);
        prev = 8'h6e;
    endtask : t_err

    task automatic t_undef;
        logic [3:0] u [4];
        u = '{4'h0, 4'h7, 4'hb, 4'hf};
        wr(OFS_IRQ_STAT, 32'h7);
        for (int k = 0; k < 4; k++) begin
            frame({u[k], 4'h4}, 8, prev);
            prev = {u[k], 4'h4};
        end
        rchk(OFS_IRQ_STAT, 32'h4);
        wr(OFS_CTRL, 32'h0);
        frame(8'ha1, 8, prev);
        wr(OFS_CTRL, 32'h1);
        exp_outs[3:0] = 4'h2;
        frame(8'ha2, 8, 8'ha1);
        prev = 8'ha2;
    endtask : t_undef

    task automatic t_irq;
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'h1);
        rchk(OFS_IRQ_MASK, 32'h1);
        irq_chk(1'b0);
        frame(8'h44, 5, 8'h00);
        irq_chk(1'b1);
        wr(OFS_IRQ_STAT, 32'h1);
        irq_chk(1'b0);
        wr(OFS_IRQ_MASK, 32'h2);
        exp_outs[15:12] = 4'h4;
        frame(8'h44, 8, ERR_CODE);
        irq_chk(1'b1);
        wr(OFS_IRQ_MASK, 32'h0);
        irq_chk(1'b0);
    endtask : t_irq

    // Write while frozen must not land
    task automatic t_freeze;
        @(posedge clk_i);
        en_i <= 1'b0;
        wr(OFS_IRQ_MASK, 32'h7);
        @(posedge clk_i);
        en_i <= 1'b1;
        rchk(OFS_IRQ_MASK, 32'h0);
    endtask : t_freeze

    // Reset in mid-run clears outputs and the echo byte
    task automatic t_rst2;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rchk(OFS_LAST_CMD, 32'h0);
        chk({12'h0, squib, mux, low, aux, high}, 32'h0);
        chk({31'h0, sdo_oe_n_o}, 32'h1);
        exp_outs = 20'h1_0000;
        frame(8'h31, 8, 8'h00);
    endtask : t_rst2

    task automatic wrap_up;
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_cmds();
        t_reads();
        t_err();
        t_undef();
        t_irq();
        t_freeze();
        t_rst2();
        wrap_up();
    end

    // About 30 frames of half a microsecond each, with wide margin
    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
endmodule : tb_asp_port
`default_nettype wire

// >>> verilog/asp_pkg.sv
// Constants and types shared by the serial command port.
// Assumes a 200 MHz core clock; all pins are sampled by that clock.
package asp_pkg;

    // Serial frame
    localparam int         FRAME_BITS = 8;
    localparam int         CNT_W      = 4;
    localparam logic [3:0] CNT_VALID  = 4'h8;
    localparam logic [3:0] CNT_MAX    = 4'hf;
    localparam logic [3:0] CNT_ZERO   = 4'h0;
    localparam logic [3:0] CNT_ONE    = 4'h1;
    localparam logic [7:0] ERR_CODE   = 8'hfe;

    // Command codes in the upper nibble
    localparam logic [3:0] CMD_RD_STAT  = 4'h1;
    localparam logic [3:0] CMD_RD_FAULT = 4'h2;
    localparam logic [3:0] CMD_SQUIB    = 4'h3;
    localparam logic [3:0] CMD_MUX      = 4'h4;
    localparam logic [3:0] CMD_LOW      = 4'h5;
    localparam logic [3:0] CMD_AUX      = 4'h6;
    localparam logic [3:0] CMD_HIGH     = 4'ha;

    // Command targets
    localparam int         TGT_N     = 5;
    localparam logic [2:0] TGT_SQUIB = 3'h0;
    localparam logic [2:0] TGT_MUX   = 3'h1;
    localparam logic [2:0] TGT_LOW   = 3'h2;
    localparam logic [2:0] TGT_AUX   = 3'h3;
    localparam logic [2:0] TGT_HIGH  = 3'h4;
    localparam logic [2:0] TGT_NONE  = 3'h7;
    localparam logic [3:0] TGT_RST   = 4'h0;

    // Synchroniser lanes
    localparam int SYNC_SEL      = 0;
    localparam int SYNC_CLK      = 1;
    localparam int SYNC_DIN      = 2;
    localparam int SYNC_STAT_LSB = 3;
    localparam int STAT_FLAGS    = 6;
    localparam int SYNC_FLT_LSB  = 9;
    localparam int FLT_FLAGS     = 4;
    localparam int SYNC_W        = 13;
    localparam logic [1:0] STAT_PAD = 2'h0;
    localparam logic [3:0] FLT_PAD  = 4'h0;

    // Register port
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 32;
    localparam logic [3:0]  OFS_CTRL     = 4'h0;
    localparam logic [3:0]  OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0]  OFS_IRQ_MASK = 4'h8;
    localparam logic [3:0]  OFS_LAST_CMD = 4'hc;
    localparam int          CTRL_EXEC    = 0;
    localparam logic        CTRL_RST     = 1'b1;
    localparam int          IRQ_W        = 3;
    localparam int          IRQ_FRAME_ERR = 0;
    localparam int          IRQ_CMD_DONE = 1;
    localparam int          IRQ_CMD_BAD  = 2;
    localparam logic [2:0]  IRQ_RST      = 3'h0;
    localparam logic [31:0] RDATA_ZERO   = 32'h0;

    typedef enum logic [1:0] {
        RESP_ECHO,
        RESP_STAT,
        RESP_FAULT
    } asp_resp_t;

endpackage : asp_pkg

// >>> verilog/asp_port.sv
// Serial command port: frame check, command decode, response shifting.
// Assumes a serial clock far slower than clk_i and idle low between bits.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A frame from select rise to select fall must hold exactly eight clocks, else it errs.
// - An errored frame's input bits are thrown away and nothing is executed.
// - After a frame error the error byte is sent in every following frame up to and including the next one with a valid count.
// - The response goes out MSB first; it is loaded at select rise and changes otherwise only on falling serial clock edges.
// - One bit leaves and one bit enters on every serial clock cycle of a frame.
// - The response is the previous byte, the status byte, the fault byte or the error code.
// - The eight bits shifted in form the command, acted on only when a valid frame closes.
// - The upper nibble picks the command, the lower nibble carries its data.
// - A byte with an undefined upper nibble changes no command output; it is still kept as the echo byte and flags a bad command.
// - A status or fault read sends that register in the following frame, valid or not.
// - The status byte is zero, zero, loop 1, loop 2, safing, reserve, battery, pump flags.
// - The fault byte is four zeros, loop 2 and loop 1 high-over, loop 2 and loop 1 low-under.
module asp_port
    import asp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        en_i,
    // Register port
    input  wire logic [asp_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [asp_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [asp_pkg::DATA_W-1:0]  reg_rdata_o,
    output logic                             irq_o,
    // Serial link
    input  wire logic                        frame_sel_i,
    input  wire logic                        sclk_i,
    input  wire logic                        sdi_i,
    output logic                             sdo_o,
    output logic                             sdo_oe_n_o,
    // Status flags
    input  wire logic                        loop1_drivers_active_i,
    input  wire logic                        loop2_drivers_active_i,
    input  wire logic                        safing_closed_flag_i,
    input  wire logic                        reserve_low_flag_i,
    input  wire logic                        battery_low_flag_i,
    input  wire logic                        pump_low_flag_i,
    // Fault flags
    input  wire logic                        loop1_high_over_flag_i,
    input  wire logic                        loop2_high_over_flag_i,
    input  wire logic                        loop1_low_under_flag_i,
    input  wire logic                        loop2_low_under_flag_i,
    // Command outputs
    output logic      [3:0]                  squib_sel_o,
    output logic      [3:0]                  mux_sel_o,
    output logic      [3:0]                  low_side_o,
    output logic      [3:0]                  aux_ctrl_o,
    output logic      [3:0]                  high_side_o
);
    import asp_pkg::*;

    // Command nibble to target slot
    function automatic logic [2:0] tgt_idx(input logic [3:0] code);
        logic [2:0] idx;
        idx = TGT_NONE;
        unique case (code)
            CMD_SQUIB: idx = TGT_SQUIB;
            CMD_MUX:   idx = TGT_MUX;
            CMD_LOW:   idx = TGT_LOW;
            CMD_AUX:   idx = TGT_AUX;
            CMD_HIGH:  idx = TGT_HIGH;
            default:   idx = TGT_NONE;
        endcase
        return idx;
    endfunction : tgt_idx

    // Pin synchronisers
    logic [SYNC_W-1:0] lvl;
    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] fall;

    asp_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (en_i),
        .async_i ({loop2_high_over_flag_i, loop1_high_over_flag_i,
                   loop2_low_under_flag_i, loop1_low_under_flag_i,
                   loop1_drivers_active_i, loop2_drivers_active_i,
                   safing_closed_flag_i, reserve_low_flag_i,
                   battery_low_flag_i, pump_low_flag_i,
                   sdi_i, sclk_i, frame_sel_i}),
        .level_o (lvl),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    logic       frame_start;
    logic       frame_end;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       din_s;
    logic [7:0] status_byte;
    logic [7:0] fault_byte;

    assign frame_start = rise[SYNC_SEL];
    assign frame_end   = fall[SYNC_SEL];
    assign sclk_rise   = rise[SYNC_CLK];
    assign sclk_fall   = fall[SYNC_CLK];
    assign din_s       = lvl[SYNC_DIN];
    assign status_byte = {STAT_PAD, lvl[SYNC_STAT_LSB +: STAT_FLAGS]};
    assign fault_byte  = {FLT_PAD, lvl[SYNC_FLT_LSB +: FLT_FLAGS]};

    // Frame state
    logic             act_reg,      act_next;
    logic [CNT_W-1:0] cnt_reg,      cnt_next;
    logic [7:0]       rx_reg,       rx_next;
    logic [7:0]       tx_reg,       tx_next;
    logic             err_pend_reg, err_pend_next;
    asp_resp_t        resp_reg,     resp_next;
    logic [7:0]       last_cmd_reg, last_cmd_next;
    logic [3:0]       tgt_reg  [TGT_N];
    logic [3:0]       tgt_next [TGT_N];
    logic [7:0]       resp_byte;
    logic [2:0]       rx_tgt;
    logic             evt_err;
    logic             evt_done;
    logic             evt_bad;
    logic             ctrl_reg;

    always_comb begin
        unique case (resp_reg)
            RESP_STAT:  resp_byte = status_byte;
            RESP_FAULT: resp_byte = fault_byte;
            RESP_ECHO:  resp_byte = last_cmd_reg;
            default:    resp_byte = last_cmd_reg;
        endcase
    end

    assign rx_tgt = tgt_idx(rx_reg[7:4]);

    always_comb begin
        act_next      = act_reg;
        cnt_next      = cnt_reg;
        rx_next       = rx_reg;
        tx_next       = tx_reg;
        err_pend_next = err_pend_reg;
        resp_next     = resp_reg;
        last_cmd_next = last_cmd_reg;
        tgt_next      = tgt_reg;
        evt_err       = 1'b0;
        evt_done      = 1'b0;
        evt_bad       = 1'b0;
        if (frame_start) begin
            act_next = 1'b1;
            cnt_next = CNT_ZERO;
            tx_next  = err_pend_reg ? ERR_CODE : resp_byte;
        end else if (act_reg) begin
            if (sclk_rise) begin
                rx_next = {rx_reg[6:0], din_s};
                if (cnt_reg != CNT_MAX) begin
                    cnt_next = cnt_reg + CNT_ONE;
                end
            end
            if (sclk_fall && cnt_reg != CNT_ZERO) begin
                tx_next = {tx_reg[6:0], 1'b0};
            end
            if (frame_end) begin
                act_next = 1'b0;
                if (cnt_reg != CNT_VALID) begin
                    err_pend_next = 1'b1;
                    evt_err       = 1'b1;
                end else begin
                    err_pend_next = 1'b0;
                    last_cmd_next = rx_reg;
                    resp_next     = RESP_ECHO;
                    evt_done      = 1'b1;
                    if (rx_reg[7:4] == CMD_RD_STAT) begin
                        resp_next = RESP_STAT;
                    end else if (rx_reg[7:4] == CMD_RD_FAULT) begin
                        resp_next = RESP_FAULT;
                    end else if (rx_tgt != TGT_NONE) begin
                        if (ctrl_reg) begin
                            tgt_next[rx_tgt] = rx_reg[3:0];
                        end
                    end else begin
                        evt_done = 1'b0;
                        evt_bad  = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            act_reg      <= 1'b0;
            cnt_reg      <= CNT_ZERO;
            rx_reg       <= '0;
            tx_reg       <= '0;
            err_pend_reg <= 1'b0;
            resp_reg     <= RESP_ECHO;
            last_cmd_reg <= '0;
            for (int i = 0; i < TGT_N; i++) begin
                tgt_reg[i] <= TGT_RST;
            end
        end else if (en_i) begin
            act_reg      <= act_next;
            cnt_reg      <= cnt_next;
            rx_reg       <= rx_next;
            tx_reg       <= tx_next;
            err_pend_reg <= err_pend_next;
            resp_reg     <= resp_next;
            last_cmd_reg <= last_cmd_next;
            tgt_reg      <= tgt_next;
        end
    end

    assign sdo_o       = tx_reg[7];
    assign sdo_oe_n_o  = ~act_reg;
    assign squib_sel_o = tgt_reg[TGT_SQUIB];
    assign mux_sel_o   = tgt_reg[TGT_MUX];
    assign low_side_o  = tgt_reg[TGT_LOW];
    assign aux_ctrl_o  = tgt_reg[TGT_AUX];
    assign high_side_o = tgt_reg[TGT_HIGH];

    // Register file and interrupt
    logic              ctrl_next;
    logic [IRQ_W-1:0]  irq_stat_reg, irq_stat_next;
    logic [IRQ_W-1:0]  irq_mask_reg, irq_mask_next;
    logic [DATA_W-1:0] rdata_reg,    rdata_next;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_FRAME_ERR] = evt_err;
        irq_set[IRQ_CMD_DONE]  = evt_done;
        irq_set[IRQ_CMD_BAD]   = evt_bad;
        irq_clr   = '0;
        ctrl_next = ctrl_reg;
        irq_mask_next = irq_mask_reg;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_CTRL:     ctrl_next     = reg_wdata_i[CTRL_EXEC];
                OFS_IRQ_STAT: irq_clr       = reg_wdata_i[IRQ_W-1:0];
                OFS_IRQ_MASK: irq_mask_next = reg_wdata_i[IRQ_W-1:0];
                default:      ;
            endcase
        end
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
        rdata_next = RDATA_ZERO;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_CTRL:     rdata_next[CTRL_EXEC]   = ctrl_reg;
                OFS_IRQ_STAT: rdata_next[IRQ_W-1:0]   = irq_stat_reg;
                OFS_IRQ_MASK: rdata_next[IRQ_W-1:0]   = irq_mask_reg;
                OFS_LAST_CMD: rdata_next[7:0]         = last_cmd_reg;
                default:      rdata_next              = RDATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg     <= CTRL_RST;
            irq_stat_reg <= IRQ_RST;
            irq_mask_reg <= IRQ_RST;
            rdata_reg    <= RDATA_ZERO;
        end else if (en_i) begin
            ctrl_reg     <= ctrl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign irq_o       = |(irq_stat_reg & irq_mask_reg);

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_count_err;
        act_reg && frame_end && cnt_reg != CNT_VALID |=> err_pend_reg && irq_stat_reg[IRQ_FRAME_ERR];
    endproperty
    a_count_err: assert property (p_count_err)
        else $error("short or long frame not flagged");

    property p_err_discard;
        act_reg && frame_end && cnt_reg != CNT_VALID
            |=> $stable(last_cmd_reg) && $stable(squib_sel_o) && $stable(high_side_o);
    endproperty
    a_err_discard: assert property (p_err_discard)
        else $error("errored frame changed state");

    property p_err_code;
        frame_start && err_pend_reg |=> tx_reg == ERR_CODE && sdo_o;
    endproperty
    a_err_code: assert property (p_err_code)
        else $error("error code not loaded");

    property p_sdo_hold;
        act_reg && !frame_start && !(sclk_fall && cnt_reg != CNT_ZERO) |=> $stable(sdo_o);
    endproperty
    a_sdo_hold: assert property (p_sdo_hold)
        else $error("serial output moved off a falling edge");

    property p_shift_in;
        en_i && act_reg && !frame_start && sclk_rise
            |=> rx_reg == {$past(rx_reg[6:0]), $past(din_s)};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("input bit not shifted in");

    property p_exec;
        act_reg && frame_end && cnt_reg == CNT_VALID && rx_reg[7:4] == CMD_SQUIB && ctrl_reg
            |=> squib_sel_o == $past(rx_reg[3:0]);
    endproperty
    a_exec: assert property (p_exec)
        else $error("valid command not executed");

    property p_ignore;
        act_reg && frame_end && cnt_reg == CNT_VALID && tgt_idx(rx_reg[7:4]) == TGT_NONE
            && rx_reg[7:4] != CMD_RD_STAT && rx_reg[7:4] != CMD_RD_FAULT
            |=> $stable(mux_sel_o) && $stable(aux_ctrl_o) && irq_stat_reg[IRQ_CMD_BAD];
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("undefined command changed state");

    property p_read_stat;
        frame_start && !err_pend_reg && resp_reg == RESP_STAT
            |=> tx_reg == {STAT_PAD, $past(lvl[SYNC_STAT_LSB +: STAT_FLAGS])};
    endproperty
    a_read_stat: assert property (p_read_stat)
        else $error("status byte not sent");

    property p_release;
        frame_end && act_reg |=> sdo_oe_n_o ##1 (sdo_oe_n_o || frame_start);
    endproperty
    a_release: assert property (p_release)
        else $error("serial output not released");

endmodule : asp_port
`default_nettype wire

// >>> verilog/asp_sync.sv
// Two-stage synchroniser with edge pulses for a bundle of pins.
// Assumes inputs are asynchronous to clk_i and change slower than it.
`timescale 1ns/1ps
`default_nettype none
module asp_sync #(
    parameter int W = 1
) (
    // Clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         en_i,
    // Pins and synchronised views
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else if (en_i) begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Per-lane edge detection on the second stage only
    for (genvar g = 0; g < W; g++) begin : g_edge
        assign rise_o[g] = en_i & sync_reg[g] & ~prev_reg[g];
        assign fall_o[g] = en_i & ~sync_reg[g] & prev_reg[g];
    end

    assign level_o = sync_reg;

endmodule : asp_sync
`default_nettype wire
